//--- logic/pao_pin_mux.sv
/*
  one group of port pins: applies override enables and values to the port
  register bits and synchronises the pin inputs.
  assumes override terms come from logic on the same clock.
*/
`timescale 1ns/1ps
module pao_pin_mux
  import pao_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_port_out,
  input  wire logic [W-1:0] i_port_dir,
  input  wire logic         i_pud,
  input  wire logic [W-1:0] i_pullup_override_en,
  input  wire logic [W-1:0] i_pullup_override_val,
  input  wire logic [W-1:0] i_dir_override_en,
  input  wire logic [W-1:0] i_dir_override_val,
  input  wire logic [W-1:0] i_portval_override_en,
  input  wire logic [W-1:0] i_portval_override_val,
  input  wire logic [W-1:0] i_input_enable_override_en,
  input  wire logic [W-1:0] i_input_enable_override_val,
  input  wire logic [W-1:0] i_pin_in,
  output logic      [W-1:0] o_pin_out,
  output logic      [W-1:0] o_pin_oe_n,
  output logic      [W-1:0] o_pullup,
  output logic      [W-1:0] o_input_en,
  output logic      [W-1:0] o_pin_sync
);
  // ==========================================================
  // override selection
  logic [W-1:0] dir_nxt;
  logic [W-1:0] meta_r;

  assign dir_nxt = (i_dir_override_en & i_dir_override_val) | (~i_dir_override_en & i_port_dir);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_out  <= '0;
      o_pin_oe_n <= {W{OE_N_RST}};
      o_pullup   <= '0;
      o_input_en <= '0;
    end else begin
      o_pin_out  <= (i_portval_override_en & i_portval_override_val) | (~i_portval_override_en & i_port_out);
      o_pin_oe_n <= ~dir_nxt;
      // register pull-up: output bit set, pin an input, no global disable
      o_pullup   <= (i_pullup_override_en & i_pullup_override_val) | (~i_pullup_override_en & i_port_out & ~dir_nxt & {W{~i_pud}});
      o_input_en <= (i_input_enable_override_en & i_input_enable_override_val) | ~i_input_enable_override_en;
    end
  end

  // ==========================================================
  // input synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r     <= '0;
      o_pin_sync <= '0;
    end else begin
      meta_r     <= i_pin_in;
      o_pin_sync <= meta_r;
    end
  end
endmodule

//--- logic/pao_pkg.sv
/*
  shared constants of the port override block: pin positions, field widths,
  reset values and mask-field limits.
  assumes one system clock and an active-low asynchronous reset.
*/
package pao_pkg;
  localparam int          PORT_W        = 8;
  localparam int          PORTD_LSB     = 3;
  localparam int          PORTD_W       = 5;
  localparam int          MASK_W        = 3;
  localparam int          SYNC_STAGES   = 2;
  // port b pin positions
  localparam int          PB_SEL_BIT    = 0;
  localparam int          PB_SCK_BIT    = 1;
  localparam int          PB_MOSI_BIT   = 2;
  localparam int          PB_MISO_BIT   = 3;
  localparam int          PB_CMP_LSB    = 4;
  localparam int          PB_CMP7_BIT   = 7;
  // port d pin positions
  localparam int          PD_TX_BIT     = 3;
  localparam int          PD_CAP_BIT    = 4;
  localparam int          PD_XCK_BIT    = 5;
  localparam int          PD_T1_BIT     = 6;
  localparam int          PD_T2_BIT     = 7;
  localparam int          PD_XCK_DIR    = 4;
  // reset values
  localparam logic        LEGACY_RST    = 1'b1;
  localparam logic        OE_N_RST      = 1'b1;
  localparam logic [2:0]  MASK_ZERO     = 3'h0;
  // per-pin mask limits for port c pins 0..7
  localparam logic [31:0] XMM_LIMITS    = 32'h1234_5677;
endpackage

//--- logic/pao_port_override.sv
/*
  alternate-function override logic for port b, port c and port d bits 7..3.
  assumes peripheral enables and outputs come from logic on i_sys_clk and that
  the pin inputs are asynchronous.
*/
// Overview of operation
// - spi slave role forces the select pin to input, ignoring its direction bit.
// - slave spi is active only while the master holds select low.
// - spi master role leaves select pin direction to its port direction bit.
// - select pin forced to input keeps pull-up from its port output bit.
// - miso and mosi carry master or slave data according to the spi role.
// - upper port b pins: compare output replaces port value when enabled.
// - legacy mode: pin b7 carries only the 8-bit timer compare output.
// - spi pins: overrides depend on enable and role; direction override is zero.
// - legacy mode: port c is output only, no input.
// - device starts in legacy mode; port c drives outputs until it is left.
// - port c pins 7..0 carry external address bits 15..8.
// - port c pins 7..4 drive address when mask field below 1..4.
// - port c pins 3..0 drive address when mask field below 5,6,7,7.
// - legacy mode treats mask field as zero.
// - legacy mode removes second usart clock and transmit functions.
// - usart clock pin outputs when printed direction bit set, else input.
// - usart clock pin function only in synchronous mode.
// - port d bit 4 feeds capture; bits 7, 6 feed timer count sources.
// - usart transmitter enabled forces port d bit 3 to output.
// - port d bit 3 also feeds external interrupt 3.
`timescale 1ns/1ps
module pao_port_override
  import pao_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_legacy_exit,
  input  wire logic                 i_global_pullup_disable,
  input  wire logic [PORT_W-1:0]    i_portb_out,
  input  wire logic [PORT_W-1:0]    i_portb_dir,
  input  wire logic [PORT_W-1:0]    i_portc_out,
  input  wire logic [PORT_W-1:0]    i_portc_dir,
  input  wire logic [PORTD_W-1:0]   i_portd_out,
  input  wire logic [PORTD_W-1:0]   i_portd_dir,
  input  wire logic                 i_spi_enable_bit,
  input  wire logic                 i_spi_master_select,
  input  wire logic                 i_spi_master_out,
  input  wire logic                 i_spi_slave_out,
  input  wire logic                 i_spi_sck_out,
  input  wire logic [3:0]           i_cmp_en,
  input  wire logic                 i_timer0_compare_out,
  input  wire logic                 i_timer1_compare_a_out,
  input  wire logic                 i_timer1_compare_b_out,
  input  wire logic                 i_timer1_compare_c_out,
  input  wire logic                 i_timer1_c_en,
  input  wire logic                 i_timer2_compare_out,
  input  wire logic                 i_xmem_enable,
  input  wire logic [MASK_W-1:0]    i_xmem_high_addr_mask,
  input  wire logic [PORT_W-1:0]    i_xmem_addr_hi,
  input  wire logic                 i_usart_b_sync_mode,
  input  wire logic                 i_usart_b_clk_out,
  input  wire logic                 i_usart_b_tx_en,
  input  wire logic                 i_usart_b_transmit,
  input  wire logic                 i_ext_irq3_en,
  input  wire logic [PORT_W-1:0]    i_portb_pin,
  input  wire logic [PORT_W-1:0]    i_portc_pin,
  input  wire logic [PORTD_W-1:0]   i_portd_pin,
  output logic      [PORT_W-1:0]    o_portb_pin,
  output logic      [PORT_W-1:0]    o_portb_oe_n,
  output logic      [PORT_W-1:0]    o_portb_pullup,
  output logic      [PORT_W-1:0]    o_portb_input_en,
  output logic      [PORT_W-1:0]    o_portc_pin,
  output logic      [PORT_W-1:0]    o_portc_oe_n,
  output logic      [PORT_W-1:0]    o_portc_pullup,
  output logic      [PORT_W-1:0]    o_portc_input_en,
  output logic      [PORTD_W-1:0]   o_portd_pin,
  output logic      [PORTD_W-1:0]   o_portd_oe_n,
  output logic      [PORTD_W-1:0]   o_portd_pullup,
  output logic      [PORTD_W-1:0]   o_portd_input_en,
  output logic                      o_legacy_mode,
  output logic                      o_spi_slave_active,
  output logic                      o_spi_master_in,
  output logic                      o_spi_slave_in,
  output logic                      o_spi_sck_in,
  output logic                      o_timer1_capture_in,
  output logic                      o_timer1_count_src,
  output logic                      o_timer2_count_src,
  output logic                      o_usart_b_ext_clock,
  output logic                      o_ext_irq3
);
  // ==========================================================
  // mode state
  logic                 legacy_r;
  logic                 spi_master;
  logic                 spi_slave;
  logic [MASK_W-1:0]    mask_eff;
  logic                 xck_act;
  logic                 tx_act;
  logic [PORT_W-1:0]    sync_b;
  logic [PORT_W-1:0]    sync_c;
  logic [PORTD_W-1:0]   sync_d;

  function automatic logic xmm_below(input logic [MASK_W-1:0] m, input int pin);
    logic [3:0] lim;
    lim = XMM_LIMITS[pin*4 +: 4];
    return {1'b0, m} < lim;
  endfunction

  // legacy mode holds from reset until software asks to leave it
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      legacy_r <= LEGACY_RST;
    end else if (i_legacy_exit) begin
      legacy_r <= 1'b0;
    end
  end
  assign o_legacy_mode = legacy_r;

  assign spi_master = i_spi_enable_bit & i_spi_master_select;
  assign spi_slave  = i_spi_enable_bit & ~i_spi_master_select;
  assign mask_eff   = legacy_r ? MASK_ZERO : i_xmem_high_addr_mask;
  assign xck_act    = i_usart_b_sync_mode & ~legacy_r;
  assign tx_act     = i_usart_b_tx_en & ~legacy_r;

  // ==========================================================
  // port b overrides
  logic [PORT_W-1:0] b_pullup_override_en, b_pullup_override_val, b_dir_override_en, b_dir_override_val, b_portval_override_en, b_portval_override_val;
  logic              b7_c_en;

  assign b7_c_en = i_timer1_c_en & ~legacy_r;

  always_comb begin
    b_pullup_override_en = '0;
    b_pullup_override_val = '0;
    b_dir_override_en = '0;
    b_dir_override_val = '0;
    b_portval_override_en = '0;
    b_portval_override_val = '0;
    // spi pins: input-forced pins feed the spi; pull-up from output bit
    for (int i = PB_SEL_BIT; i <= PB_MISO_BIT; i++) begin
      b_pullup_override_en[i] = (i == PB_SEL_BIT || i == PB_MISO_BIT) ? spi_master : spi_slave;
      b_pullup_override_val[i] = i_portb_out[i] & ~i_global_pullup_disable;
    end
    b_dir_override_en[PB_MISO_BIT] = spi_master;
    b_dir_override_en[PB_MOSI_BIT] = spi_slave;
    b_dir_override_en[PB_SCK_BIT]  = spi_slave;
    b_dir_override_en[PB_SEL_BIT]  = spi_slave;
    b_portval_override_en[PB_MISO_BIT] = spi_slave;
    b_portval_override_val[PB_MISO_BIT] = i_spi_slave_out;
    b_portval_override_en[PB_MOSI_BIT] = spi_master;
    b_portval_override_val[PB_MOSI_BIT] = i_spi_master_out;
    b_portval_override_en[PB_SCK_BIT]  = spi_master;
    b_portval_override_val[PB_SCK_BIT]  = i_spi_sck_out;
    // compare outputs never touch pull-up, direction or input
    b_portval_override_en[PB_CMP_LSB +: 4] = {i_cmp_en[3] | b7_c_en, i_cmp_en[2:0]};
    b_portval_override_val[PB_CMP_LSB]      = i_timer0_compare_out;
    b_portval_override_val[PB_CMP_LSB + 1]  = i_timer1_compare_a_out;
    b_portval_override_val[PB_CMP_LSB + 2]  = i_timer1_compare_b_out;
    b_portval_override_val[PB_CMP7_BIT]     = (i_cmp_en[3] & i_timer2_compare_out) | (b7_c_en & i_timer1_compare_c_out);
  end

  // ==========================================================
  // port c overrides
  logic [PORT_W-1:0] c_addr_en;
  for (genvar g = 0; g < PORT_W; g++) begin : g_c
    assign c_addr_en[g] = i_xmem_enable & xmm_below(mask_eff, g);
  end

  // ==========================================================
  // port d overrides, vector index 0 is pin 3
  logic [PORTD_W-1:0] d_oe, d_ov, d_portval_override_en, d_portval_override_val;
  always_comb begin
    d_oe   = '0;
    d_ov   = '0;
    d_portval_override_en = '0;
    d_portval_override_val = '0;
    d_oe[PD_TX_BIT - PORTD_LSB]    = tx_act;
    d_ov[PD_TX_BIT - PORTD_LSB]    = 1'b1;
    d_portval_override_en[PD_TX_BIT - PORTD_LSB]  = tx_act;
    d_portval_override_val[PD_TX_BIT - PORTD_LSB]  = i_usart_b_transmit;
    d_oe[PD_XCK_BIT - PORTD_LSB]   = xck_act;
    d_ov[PD_XCK_BIT - PORTD_LSB]   = i_portd_dir[PD_XCK_DIR - PORTD_LSB];
    d_portval_override_en[PD_XCK_BIT - PORTD_LSB] = xck_act;
    d_portval_override_val[PD_XCK_BIT - PORTD_LSB] = i_usart_b_clk_out;
  end

  // ==========================================================
  // pin groups
  pao_pin_mux #(.W(PORT_W)) u_portb (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_port_out (i_portb_out),
    .i_port_dir (i_portb_dir),
    .i_pud      (i_global_pullup_disable),
    .i_pullup_override_en     (b_pullup_override_en),
    .i_pullup_override_val     (b_pullup_override_val),
    .i_dir_override_en     (b_dir_override_en),
    .i_dir_override_val     (b_dir_override_val),
    .i_portval_override_en     (b_portval_override_en),
    .i_portval_override_val     (b_portval_override_val),
    .i_input_enable_override_en    ('0),
    .i_input_enable_override_val    ('0),
    .i_pin_in   (i_portb_pin),
    .o_pin_out  (o_portb_pin),
    .o_pin_oe_n (o_portb_oe_n),
    .o_pullup   (o_portb_pullup),
    .o_input_en (o_portb_input_en),
    .o_pin_sync (sync_b)
  );

  pao_pin_mux #(.W(PORT_W)) u_portc (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_port_out (i_portc_out),
    .i_port_dir (i_portc_dir),
    .i_pud      (i_global_pullup_disable),
    .i_pullup_override_en     (c_addr_en),
    .i_pullup_override_val     ('0),
    .i_dir_override_en     (c_addr_en | {PORT_W{legacy_r}}),
    .i_dir_override_val     ('1),
    .i_portval_override_en     (c_addr_en),
    .i_portval_override_val     (i_xmem_addr_hi),
    .i_input_enable_override_en    ({PORT_W{legacy_r}}),
    .i_input_enable_override_val    ('0),
    .i_pin_in   (i_portc_pin),
    .o_pin_out  (o_portc_pin),
    .o_pin_oe_n (o_portc_oe_n),
    .o_pullup   (o_portc_pullup),
    .o_input_en (o_portc_input_en),
    .o_pin_sync (sync_c)
  );

  pao_pin_mux #(.W(PORTD_W)) u_portd (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_port_out (i_portd_out),
    .i_port_dir (i_portd_dir),
    .i_pud      (i_global_pullup_disable),
    .i_pullup_override_en     (d_oe),
    .i_pullup_override_val     ('0),
    .i_dir_override_en     (d_oe),
    .i_dir_override_val     (d_ov),
    .i_portval_override_en     (d_portval_override_en),
    .i_portval_override_val     (d_portval_override_val),
    .i_input_enable_override_en    ({{(PORTD_W-1){1'b0}}, i_ext_irq3_en}),
    .i_input_enable_override_val    ({{(PORTD_W-1){1'b0}}, 1'b1}),
    .i_pin_in   (i_portd_pin),
    .o_pin_out  (o_portd_pin),
    .o_pin_oe_n (o_portd_oe_n),
    .o_pullup   (o_portd_pullup),
    .o_input_en (o_portd_input_en),
    .o_pin_sync (sync_d)
  );

  // ==========================================================
  // inputs to peripherals
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_spi_slave_active  <= 1'b0;
      o_spi_master_in     <= 1'b0;
      o_spi_slave_in      <= 1'b0;
      o_spi_sck_in        <= 1'b0;
    end else begin
      o_spi_slave_active  <= spi_slave & ~sync_b[PB_SEL_BIT];
      o_spi_master_in     <= sync_b[PB_MISO_BIT];
      o_spi_slave_in      <= sync_b[PB_MOSI_BIT];
      o_spi_sck_in        <= sync_b[PB_SCK_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_timer1_capture_in <= 1'b0;
      o_timer1_count_src  <= 1'b0;
      o_timer2_count_src  <= 1'b0;
      o_usart_b_ext_clock <= 1'b0;
      o_ext_irq3          <= 1'b0;
    end else begin
      o_timer1_capture_in <= sync_d[PD_CAP_BIT - PORTD_LSB];
      o_timer1_count_src  <= sync_d[PD_T1_BIT - PORTD_LSB];
      o_timer2_count_src  <= sync_d[PD_T2_BIT - PORTD_LSB];
      o_usart_b_ext_clock <= xck_act & sync_d[PD_XCK_BIT - PORTD_LSB];
      o_ext_irq3          <= sync_d[PD_TX_BIT - PORTD_LSB];
    end
  end

  // ==========================================================
  // assertions
  sequence s_sel_low;
    (spi_slave && !i_portb_pin[PB_SEL_BIT]) [*3];
  endsequence

  property p_slave_sel_in;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      spi_slave |=> o_portb_oe_n[PB_SEL_BIT] && o_portb_pullup[PB_SEL_BIT] == $past(b_pullup_override_val[PB_SEL_BIT]);
  endproperty
  a_slave_sel_in: assert property (p_slave_sel_in) else $error("select pin not forced to input");

  property p_slave_active;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_sel_low |=> o_spi_slave_active;
  endproperty
  a_slave_active: assert property (p_slave_active) else $error("slave not active with select low");

  property p_master_sel_dir;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      spi_master |=> o_portb_oe_n[PB_SEL_BIT] == !$past(i_portb_dir[PB_SEL_BIT]);
  endproperty
  a_master_sel_dir: assert property (p_master_sel_dir) else $error("select pin direction overridden");

  property p_forced_pullup;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      spi_slave |=> o_portb_pullup[PB_SCK_BIT] == ($past(i_portb_out[PB_SCK_BIT]) && !$past(i_global_pullup_disable));
  endproperty
  a_forced_pullup: assert property (p_forced_pullup) else $error("forced-input pull-up wrong");

  property p_mosi_master;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      spi_master |=> o_portb_pin[PB_MOSI_BIT] == $past(i_spi_master_out) && o_portb_oe_n[PB_MISO_BIT];
  endproperty
  a_mosi_master: assert property (p_mosi_master) else $error("mosi not master output");

  property p_legacy_b7;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      legacy_r && !i_cmp_en[3] |=> o_portb_pin[PB_CMP7_BIT] == $past(i_portb_out[PB_CMP7_BIT]);
  endproperty
  a_legacy_b7: assert property (p_legacy_b7) else $error("b7 compare c in legacy mode");

  property p_legacy_c_out;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      legacy_r |=> o_portc_oe_n == '0 && o_portc_input_en == '0;
  endproperty
  a_legacy_c_out: assert property (p_legacy_c_out) else $error("port c not output only");

  property p_addr_drive;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_xmem_enable && mask_eff == 3'h3 |=> o_portc_pin[4:0] == $past(i_xmem_addr_hi[4:0])
        && o_portc_pullup[4:0] == 5'h00 && o_portc_pin[PORT_W-1:5] == $past(i_portc_out[PORT_W-1:5]);
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address high byte mask wrong");

  property p_tx_out;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      tx_act |=> !o_portd_oe_n[PD_TX_BIT - PORTD_LSB] && o_portd_pin[PD_TX_BIT - PORTD_LSB] == $past(i_usart_b_transmit);
  endproperty
  a_tx_out: assert property (p_tx_out) else $error("transmit pin not forced out");
endmodule

//--- sim/pao_pin_model.sv
/*
  far side of one port group: external drivers and the pin wire itself.
  assumes the device drive wins over any external drive on the same pin.
*/
`timescale 1ns/1ps
module pao_pin_model #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic [W-1:0] i_pin_out,
  input  wire logic [W-1:0] i_oe_n,
  input  wire logic [W-1:0] i_pullup,
  input  wire logic [W-1:0] i_ext_en,
  input  wire logic [W-1:0] i_ext_val,
  output logic      [W-1:0] o_pin
);
  // ==========================================================
  // undriven pins float: a pattern that changes every cycle
  logic [W-1:0] float_r = '0;

  always_ff @(posedge i_sys_clk) begin
    float_r <= ~float_r;
  end

  // ==========================================================
  // wire level: device drive, else external drive, else pull-up, else floating
  assign o_pin = (~i_oe_n & i_pin_out) | (i_oe_n & i_ext_en & i_ext_val)
               | (i_oe_n & ~i_ext_en & (i_pullup | float_r));
endmodule

//--- sim/pao_port_override_bench.sv
/*
  self-checking bench of the port override block: drives peripheral and port
  register inputs, models the pins, compares outputs with expected values.
  assumes the one-cycle output latency and three-edge input path of the block.
*/
`timescale 1ns/1ps
module pao_port_override_bench
  import pao_pkg::*;
;
  // ==========================================================
  // signals
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_legacy_exit = 1'b0, i_global_pullup_disable = 1'b0;
  logic i_spi_enable_bit = 1'b0, i_spi_master_select = 1'b0, i_spi_master_out = 1'b0;
  logic i_spi_slave_out = 1'b0, i_spi_sck_out = 1'b0, i_timer0_compare_out = 1'b0;
  logic i_timer1_compare_a_out = 1'b0, i_timer1_compare_b_out = 1'b0, i_timer1_compare_c_out = 1'b0;
  logic i_timer1_c_en = 1'b0, i_timer2_compare_out = 1'b0, i_xmem_enable = 1'b0, i_ext_irq3_en = 1'b0;
  logic i_usart_b_sync_mode = 1'b0, i_usart_b_clk_out = 1'b0, i_usart_b_tx_en = 1'b0, i_usart_b_transmit = 1'b0;
  logic [3:0]        i_cmp_en = 4'h0;
  logic [MASK_W-1:0] i_xmem_high_addr_mask = 3'h0;
  logic [PORT_W-1:0] i_portb_out = 8'h00, i_portb_dir = 8'h00, i_portc_out = 8'h5a, i_portc_dir = 8'h00;
  logic [PORT_W-1:0] i_xmem_addr_hi = 8'h00, pb_ext_en = 8'h00, pb_ext_val = 8'h00;
  logic [PORTD_W-1:0] i_portd_out = 5'h00, i_portd_dir = 5'h00, pd_ext_en = 5'h00, pd_ext_val = 5'h00;
  logic [PORT_W-1:0] i_portb_pin, i_portc_pin, o_portb_pin, o_portb_oe_n, o_portb_pullup, o_portb_input_en;
  logic [PORT_W-1:0] o_portc_pin, o_portc_oe_n, o_portc_pullup, o_portc_input_en;
  logic [PORTD_W-1:0] i_portd_pin, o_portd_pin, o_portd_oe_n, o_portd_pullup, o_portd_input_en;
  logic o_legacy_mode, o_spi_slave_active, o_spi_master_in, o_spi_slave_in, o_spi_sck_in;
  logic o_timer1_capture_in, o_timer1_count_src, o_timer2_count_src, o_usart_b_ext_clock, o_ext_irq3;
  int   failures = 0;
  int   compares = 0;
  logic [7:0] drv;

  // ==========================================================
  // design and pin models
  pao_port_override dut_u (
    .i_sys_clk, .i_rstn, .i_legacy_exit, .i_global_pullup_disable, .i_portb_out, .i_portb_dir,
    .i_portc_out, .i_portc_dir, .i_portd_out, .i_portd_dir, .i_spi_enable_bit, .i_spi_master_select,
    .i_spi_master_out, .i_spi_slave_out, .i_spi_sck_out, .i_cmp_en, .i_timer0_compare_out,
    .i_timer1_compare_a_out, .i_timer1_compare_b_out, .i_timer1_compare_c_out, .i_timer1_c_en,
    .i_timer2_compare_out, .i_xmem_enable, .i_xmem_high_addr_mask, .i_xmem_addr_hi, .i_usart_b_sync_mode,
    .i_usart_b_clk_out, .i_usart_b_tx_en, .i_usart_b_transmit, .i_ext_irq3_en, .i_portb_pin, .i_portc_pin,
    .i_portd_pin, .o_portb_pin, .o_portb_oe_n, .o_portb_pullup, .o_portb_input_en, .o_portc_pin,
    .o_portc_oe_n, .o_portc_pullup, .o_portc_input_en, .o_portd_pin, .o_portd_oe_n, .o_portd_pullup,
    .o_portd_input_en, .o_legacy_mode, .o_spi_slave_active, .o_spi_master_in, .o_spi_slave_in,
    .o_spi_sck_in, .o_timer1_capture_in, .o_timer1_count_src, .o_timer2_count_src, .o_usart_b_ext_clock,
    .o_ext_irq3
  );
  pao_pin_model #(.W(PORT_W)) pb_u (.i_sys_clk(i_sys_clk), .i_pin_out(o_portb_pin), .i_oe_n(o_portb_oe_n),
    .i_pullup(o_portb_pullup), .i_ext_en(pb_ext_en), .i_ext_val(pb_ext_val), .o_pin(i_portb_pin));
  pao_pin_model #(.W(PORT_W)) pc_u (.i_sys_clk(i_sys_clk), .i_pin_out(o_portc_pin), .i_oe_n(o_portc_oe_n),
    .i_pullup(o_portc_pullup), .i_ext_en(8'h00), .i_ext_val(8'h00), .o_pin(i_portc_pin));
  pao_pin_model #(.W(PORTD_W)) pd_u (.i_sys_clk(i_sys_clk), .i_pin_out(o_portd_pin), .i_oe_n(o_portd_oe_n),
    .i_pullup(o_portd_pullup), .i_ext_en(pd_ext_en), .i_ext_val(pd_ext_val), .o_pin(i_portd_pin));

  // ==========================================================
  // clock, tasks
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge i_sys_clk);
    failures++;
    give_verdict();
  end

  // ==========================================================
  // test sequence
  initial begin
    step(11);
    check(o_portb_oe_n, 8'hff);
    check({7'h0, o_legacy_mode}, 8'h01);
    step(1);
    i_rstn = 1'b1;
    step(1);
    check({7'h0, o_legacy_mode}, 8'h01);
    check(o_portc_oe_n, 8'h00);
    check(o_portc_input_en, 8'h00);
    check(o_portc_pin, 8'h5a);
    $display("test reset done");
    // legacy mode restrictions
    i_xmem_enable = 1'b1;
    i_xmem_high_addr_mask = 3'h3;
    i_xmem_addr_hi = 8'hc3;
    i_portb_dir = 8'h80;
    i_timer1_c_en = 1'b1;
    i_timer1_compare_c_out = 1'b1;
    i_usart_b_tx_en = 1'b1;
    i_usart_b_sync_mode = 1'b1;
    i_usart_b_clk_out = 1'b1;
    i_portd_dir = 5'h02;
    step(1);
    check(o_portc_pin, 8'hc3);
    check(o_portc_pullup, 8'h00);
    check({7'h0, o_portb_pin[PB_CMP7_BIT]}, 8'h00);
    check({3'h0, o_portd_oe_n}, 8'h1d);
    check({3'h0, o_portd_pin}, 8'h00);
    $display("test legacy done");
    // leave legacy, sweep the mask field
    i_legacy_exit = 1'b1;
    step(1);
    i_legacy_exit = 1'b0;
    i_usart_b_tx_en = 1'b0;
    i_portc_out = 8'hff;
    i_xmem_addr_hi = 8'h96;
    step(1);
    check({7'h0, o_legacy_mode}, 8'h00);
    for (int m = 0; m < 8; m++) begin
      i_xmem_high_addr_mask = m[2:0];
      for (int k = 0; k < 8; k++) begin
        drv[k] = m < ((k == 0) ? 7 : 8 - k);
      end
      step(1);
      check(o_portc_pin, (8'h96 & drv) | ~drv);
      check(o_portc_oe_n, ~drv);
      check(o_portc_pullup, ~drv);
    end
    $display("test xmem mask done");
    // spi slave role
    i_xmem_enable = 1'b0;
    i_spi_enable_bit = 1'b1;
    i_portb_dir = 8'h0f;
    i_portb_out = 8'h01;
    i_spi_slave_out = 1'b1;
    pb_ext_en = 8'h07;
    pb_ext_val = 8'h04;
    step(4);
    check({4'h0, o_portb_oe_n[3:0]}, 8'h07);
    check({7'h0, o_portb_pin[PB_MISO_BIT]}, 8'h01);
    check({7'h0, o_portb_pullup[PB_SEL_BIT]}, 8'h01);
    check({5'h0, o_spi_slave_active, o_spi_slave_in, o_spi_sck_in}, 8'h06);
    pb_ext_val = 8'h05;
    i_global_pullup_disable = 1'b1;
    step(4);
    check({7'h0, o_spi_slave_active}, 8'h00);
    check({7'h0, o_portb_pullup[PB_SEL_BIT]}, 8'h00);
    $display("test spi slave done");
    // spi master role
    i_global_pullup_disable = 1'b0;
    i_spi_master_select = 1'b1;
    i_portb_dir = 8'h07;
    i_spi_master_out = 1'b1;
    i_spi_sck_out = 1'b1;
    pb_ext_en = 8'h08;
    pb_ext_val = 8'h08;
    step(4);
    check({4'h0, o_portb_oe_n[3:0]}, 8'h08);
    check({6'h0, o_portb_pin[2:1]}, 8'h03);
    check({7'h0, o_spi_master_in}, 8'h01);
    i_portb_dir = 8'h06;
    step(1);
    check({4'h0, o_portb_oe_n[3:0]}, 8'h09);
    $display("test spi master done");
    // compare outputs on port b upper pins
    i_spi_enable_bit = 1'b0;
    i_portb_dir = 8'hf0;
    i_portb_out = 8'h00;
    i_cmp_en = 4'h7;
    i_timer0_compare_out = 1'b1;
    i_timer1_compare_b_out = 1'b1;
    step(1);
    check({4'h0, o_portb_pin[7:4]}, 8'h0d);
    check({4'h0, o_portb_oe_n[7:4]}, 8'h00);
    check(o_portb_input_en, 8'hff);
    i_portb_dir = 8'h00;
    i_timer1_compare_c_out = 1'b0;
    step(1);
    check({4'h0, o_portb_oe_n[7:4]}, 8'h0f);
    check({4'h0, o_portb_pullup[7:4]}, 8'h00);
    check({4'h0, o_portb_pin[7:4]}, 8'h05);
    $display("test compare done");
    // port d functions
    i_usart_b_tx_en = 1'b1;
    i_usart_b_transmit = 1'b1;
    i_portd_dir = 5'h02;
    step(1);
    check({3'h0, o_portd_oe_n}, 8'h18);
    check({3'h0, o_portd_pin}, 8'h05);
    i_usart_b_sync_mode = 1'b0;
    step(1);
    check({3'h0, o_portd_oe_n}, 8'h1c);
    i_usart_b_sync_mode = 1'b1;
    i_usart_b_tx_en = 1'b0;
    i_portd_dir = 5'h00;
    i_ext_irq3_en = 1'b1;
    pd_ext_en = 5'h1f;
    pd_ext_val = 5'h15;
    step(4);
    check({3'h0, o_timer2_count_src, o_timer1_count_src, o_usart_b_ext_clock, o_timer1_capture_in,
           o_ext_irq3}, 8'h15);
    check({3'h0, o_portd_input_en}, 8'h1f);
    pd_ext_val = 5'h0a;
    step(4);
    check({3'h0, o_timer2_count_src, o_timer1_count_src, o_usart_b_ext_clock, o_timer1_capture_in,
           o_ext_irq3}, 8'h0a);
    $display("test port d done");
    give_verdict();
  end
endmodule
